//--- verilog/reset_state_pkg.sv
// constants shared by the reset and power-state controller
package reset_state_pkg;
  // port modes, one-hot
  typedef enum logic [3:0] {
    MODE_MCU_IO    = 4'b0001,
    MODE_LOGIC_IO  = 4'b0010,
    MODE_ADDR_OUT  = 4'b0100,
    MODE_PERIPH_IO = 4'b1000
  } port_mode_t;

  // reset phase sequencer, one-hot
  typedef enum logic [3:0] {
    PH_LOAD  = 4'b0001,
    PH_HOLD  = 4'b0010,
    PH_RUN   = 4'b0100,
    PH_APD   = 4'b1000
  } phase_t;

  localparam int          REG_WIDTH          = 8;
  localparam logic [7:0]  CTRL_RESET_VALUE   = 8'h00;
  localparam int          MAP_PERIPHERAL_IO_ENABLE_BIT     = 7;
  localparam int          MAP_SRAM_PROG_BIT  = 0;
  localparam int          LOWPWR_BIT         = 3;
  localparam logic [7:0]  MAP_DEFAULT        = 8'h00;
  // configuration load time after reset is asserted
  localparam int          CFG_LOAD_NS        = 50;
  localparam int          CLK_PERIOD_PS      = 5000;
  localparam int          CFG_LOAD_CYCLES    = (CFG_LOAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0]  CFG_LOAD_CNT_INIT  = 4'h0;
  localparam logic [1:0]  SYNC_INIT          = 2'b00;
endpackage

//--- verilog/two_flop_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module two_flop_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stageOne_ff;
  logic [WIDTH-1:0] syncOut_ff;
  logic [WIDTH-1:0] nxt_stageOne;
  logic [WIDTH-1:0] nxt_syncOut;

  // first stage is read only by the second
  always_comb begin
    nxt_stageOne = asyncIn;
    nxt_syncOut  = stageOne_ff;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stageOne_ff <= '0;
      syncOut_ff  <= '0;
    end else begin
      stageOne_ff <= nxt_stageOne;
      syncOut_ff  <= nxt_syncOut;
    end
  end

  assign syncOut = syncOut_ff;
endmodule

//--- verilog/psd_reset_state_control.sv
// reset, power-up and power-down state control for the logic and memory module
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - reset assertion loads configuration at once; logic runs well before release.
// - each reset assertion returns both flash arrays to read-array mode.
// - flash writes are blocked until the supply passes the lockout threshold.
// - first reset after power-on is power-up; later resets are warm.
// - MCU I/O pins become inputs in reset, hold state in power-down.
// - address-out pins float in reset; undefined level in power-down.
// - MCU, address-out and peripheral pins undriven in reset; peripheral floats in power-down.
// - logic I/O pins follow equations in reset; address lines blocked in power-down.
// - serial test channel stays usable in every reset and power-down state.
// - macrocell flops clear at power-up; otherwise only their reset/preset equations act.
// - mapping register reloads on any reset, keeps in power-down; bits 7 and 0 clear.
// - other control register clears on any reset, power-management pair only at power-up; all hold in power-down.
// - a configured pin signals that the SRAM runs from the backup battery.
// - low-power bit defaults to zero, so logic starts at full speed.
module psd_reset_state_control
  import reset_state_pkg::*;
#(
  parameter int          PORT_WIDTH  = 8,
  parameter logic [7:0]  MAP_CONFIG  = MAP_DEFAULT
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  rstIn_n,
  input  wire logic                  powerOnDetect,
  input  wire logic                  lockoutThresholdOk,
  input  wire logic                  automaticPowerDown,
  input  wire logic                  batterySwitched,
  input  wire logic                  standbyIndicatorEnable,
  input  wire logic [3:0]            portMode,
  input  wire logic [PORT_WIDTH-1:0] mcuOut,
  input  wire logic [PORT_WIDTH-1:0] mcuOe,
  input  wire logic [PORT_WIDTH-1:0] logicOut,
  input  wire logic [PORT_WIDTH-1:0] logicOe,
  input  wire logic [PORT_WIDTH-1:0] addrLatched,
  input  wire logic [PORT_WIDTH-1:0] periphOut,
  input  wire logic [PORT_WIDTH-1:0] periphOe,
  input  wire logic [PORT_WIDTH-1:0] macrocellNext,
  input  wire logic [PORT_WIDTH-1:0] macrocellAsyncClr,
  input  wire logic [PORT_WIDTH-1:0] macrocellAsyncSet,
  input  wire logic                  ctrlWrite,
  input  wire logic [1:0]            ctrlSelect,
  input  wire logic [7:0]            ctrlWdata,
  input  wire logic                  flashWriteReq,
  input  wire logic                  flashBusyIn,
  output logic [PORT_WIDTH-1:0]      portOut,
  output logic [PORT_WIDTH-1:0]      portOe,
  output logic [PORT_WIDTH-1:0]      macrocellQ,
  output logic [7:0]                 powerMgmtCtrlA,
  output logic [7:0]                 powerMgmtCtrlC,
  output logic [7:0]                 memoryMappingRegister,
  output logic [7:0]                 otherCtrl,
  output logic                       configLoaded,
  output logic                       flashReadArray,
  output logic                       flashWriteEnable,
  output logic                       flashAbort,
  output logic                       powerUpReset,
  output logic                       lowPowerMode,
  output logic                       addressBlocked,
  output logic                       testChannelEnable,
  output logic                       standbyIndicatorPin,
  output logic                       standbyIndicatorOe
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [4:0] pinSync;
  logic       rstAsserted;
  logic       powerOnSeen;
  logic       vddOk;
  logic       apdSync;
  logic       batterySync;

  two_flop_sync #(
    .WIDTH (5)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .asyncIn ({~rstIn_n, powerOnDetect, lockoutThresholdOk, automaticPowerDown, batterySwitched}),
    .syncOut (pinSync)
  );

  // rstIn_n is active low: inverted before sync so the cleared synchroniser reads not asserted
  assign rstAsserted = pinSync[4];
  assign powerOnSeen = pinSync[3];
  assign vddOk       = pinSync[2];
  assign apdSync     = pinSync[1];
  assign batterySync = pinSync[0];

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencer and reset-type flag
  phase_t     phase_ff;
  phase_t     nxt_phase;
  logic [3:0] loadCnt_ff;
  logic [3:0] nxt_loadCnt;
  logic       powerUp_ff;
  logic       nxt_powerUp;
  logic       rstPrev_ff;
  logic       nxt_rstPrev;
  logic       rstRise;
  logic       rstFall;

  assign rstRise = rstAsserted & ~rstPrev_ff;
  assign rstFall = ~rstAsserted & rstPrev_ff;

  // config load counts a fixed time from assertion, well before release
  always_comb begin
    nxt_phase   = phase_ff;
    nxt_loadCnt = loadCnt_ff;
    nxt_rstPrev = rstAsserted;
    nxt_powerUp = powerUp_ff;
    if (powerOnSeen) begin
      nxt_powerUp = 1'b1;
    end else if (rstFall) begin
      nxt_powerUp = 1'b0;
    end
    unique case (phase_ff)
      PH_LOAD: begin
        if (loadCnt_ff == 4'(CFG_LOAD_CYCLES - 1)) begin
          nxt_phase = PH_HOLD;
        end else begin
          nxt_loadCnt = loadCnt_ff + 4'h1;
        end
      end
      PH_HOLD: begin
        if (!rstAsserted) begin
          nxt_phase = apdSync ? PH_APD : PH_RUN;
        end
      end
      PH_RUN: begin
        if (apdSync) begin
          nxt_phase = PH_APD;
        end
      end
      PH_APD: begin
        if (!apdSync) begin
          nxt_phase = PH_RUN;
        end
      end
    endcase
    // any new assertion restarts the load
    if (rstRise) begin
      nxt_phase   = PH_LOAD;
      nxt_loadCnt = CFG_LOAD_CNT_INIT;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      phase_ff   <= PH_LOAD;
      loadCnt_ff <= CFG_LOAD_CNT_INIT;
      powerUp_ff <= 1'b1;
      rstPrev_ff <= 1'b0; // matches the cleared synchroniser, so no false release edge
    end else begin
      phase_ff   <= nxt_phase;
      loadCnt_ff <= nxt_loadCnt;
      powerUp_ff <= nxt_powerUp;
      rstPrev_ff <= nxt_rstPrev;
    end
  end

  logic inReset;
  logic inApd;
  assign inReset = rstAsserted | (phase_ff == PH_LOAD);
  assign inApd   = (phase_ff == PH_APD);

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  logic [7:0] pmA_ff, pmC_ff, map_ff, other_ff;
  logic [7:0] nxt_pmA, nxt_pmC, nxt_map, nxt_other;

  // power-up clears all but the mapping register, which reloads; warm reset spares power-management pair
  always_comb begin
    nxt_pmA   = pmA_ff;
    nxt_pmC   = pmC_ff;
    nxt_map   = map_ff;
    nxt_other = other_ff;
    if (inReset) begin
      if (powerUp_ff) begin
        nxt_pmA = CTRL_RESET_VALUE;
        nxt_pmC = CTRL_RESET_VALUE;
      end
      nxt_map                    = MAP_CONFIG;
      nxt_map[MAP_PERIPHERAL_IO_ENABLE_BIT]    = 1'b0;
      nxt_map[MAP_SRAM_PROG_BIT] = 1'b0;
      nxt_other                  = CTRL_RESET_VALUE;
    end else if (ctrlWrite && !inApd) begin
      // writes ignored in power-down so contents hold
      unique case (ctrlSelect)
        2'd0: nxt_pmA = ctrlWdata;
        2'd1: nxt_pmC = ctrlWdata;
        2'd2: nxt_map = ctrlWdata;
        2'd3: nxt_other = ctrlWdata;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pmA_ff   <= CTRL_RESET_VALUE;
      pmC_ff   <= CTRL_RESET_VALUE;
      map_ff   <= MAP_DEFAULT;
      other_ff <= CTRL_RESET_VALUE;
    end else begin
      pmA_ff   <= nxt_pmA;
      pmC_ff   <= nxt_pmC;
      map_ff   <= nxt_map;
      other_ff <= nxt_other;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins, macrocells, flash and status outputs
  logic [PORT_WIDTH-1:0] portOut_ff, portOe_ff, mc_ff;
  logic [PORT_WIDTH-1:0] nxt_portOut, nxt_portOe, nxt_mc;
  logic [7:0]            miscOut_ff, nxt_miscOut;

  // per-mode pin behaviour; mcu pins freeze in power-down
  always_comb begin
    nxt_portOut = portOut_ff;
    nxt_portOe  = portOe_ff;
    unique case (portMode)
      MODE_MCU_IO: begin
        if (inReset) begin
          nxt_portOe = '0;
        end else if (!inApd) begin
          nxt_portOut = mcuOut;
          nxt_portOe  = mcuOe;
        end
      end
      MODE_LOGIC_IO: begin
        // equations run in reset; address blocking done upstream
        nxt_portOut = logicOut;
        nxt_portOe  = logicOe;
      end
      MODE_ADDR_OUT: begin
        nxt_portOut = addrLatched;
        nxt_portOe  = inReset ? '0 : '1;
      end
      MODE_PERIPH_IO: begin
        nxt_portOut = periphOut;
        nxt_portOe  = (inReset || inApd) ? '0 : periphOe;
      end
      default: begin
        nxt_portOe = '0;
      end
    endcase
  end

  // macrocell flops: power-up clears, else async equations then data
  genvar gi;
  for (gi = 0; gi < PORT_WIDTH; gi++) begin : g_mc
    always_comb begin
      if (inReset && powerUp_ff) begin
        nxt_mc[gi] = 1'b0;
      end else if (macrocellAsyncClr[gi]) begin
        nxt_mc[gi] = 1'b0;
      end else if (macrocellAsyncSet[gi]) begin
        nxt_mc[gi] = 1'b1;
      end else if (inReset || inApd) begin
        nxt_mc[gi] = mc_ff[gi];
      end else begin
        nxt_mc[gi] = macrocellNext[gi];
      end
    end
  end

  // misc: 7 cfg, 6 readArray, 5 wrEn, 4 abort, 3 addrBlk, 2 standby, 1 standbyOe, 0 spare
  always_comb begin
    nxt_miscOut    = 8'h00;
    nxt_miscOut[7] = (phase_ff != PH_LOAD);
    nxt_miscOut[6] = inReset | ~flashBusyIn;
    nxt_miscOut[5] = vddOk & ~inReset & flashWriteReq;
    nxt_miscOut[4] = rstRise & flashBusyIn;
    nxt_miscOut[3] = inApd;
    nxt_miscOut[2] = standbyIndicatorEnable & batterySync;
    nxt_miscOut[1] = standbyIndicatorEnable;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      portOut_ff <= '0;
      portOe_ff  <= '0;
      mc_ff      <= '0;
      miscOut_ff <= 8'h00;
    end else begin
      portOut_ff <= nxt_portOut;
      portOe_ff  <= nxt_portOe;
      mc_ff      <= nxt_mc;
      miscOut_ff <= nxt_miscOut;
    end
  end

  // serial test channel never gated by reset or power-down
  logic testEn_ff;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      testEn_ff <= 1'b0;
    end else begin
      testEn_ff <= 1'b1;
    end
  end

  assign portOut               = portOut_ff;
  assign portOe                = portOe_ff;
  assign macrocellQ            = mc_ff;
  assign powerMgmtCtrlA        = pmA_ff;
  assign powerMgmtCtrlC        = pmC_ff;
  assign memoryMappingRegister = map_ff;
  assign otherCtrl             = other_ff;
  assign configLoaded          = miscOut_ff[7];
  assign flashReadArray        = miscOut_ff[6];
  assign flashWriteEnable      = miscOut_ff[5];
  assign flashAbort            = miscOut_ff[4];
  assign addressBlocked        = miscOut_ff[3];
  assign standbyIndicatorPin   = miscOut_ff[2];
  assign standbyIndicatorOe    = miscOut_ff[1];
  assign powerUpReset          = powerUp_ff;
  assign lowPowerMode          = pmA_ff[LOWPWR_BIT];
  assign testChannelEnable     = testEn_ff;
endmodule

//--- verif/psd_reset_state_control_sva.sv
// concurrent checks on the reset and power-state controller ports
`timescale 1ns/1ps
module psd_reset_state_control_sva
  import reset_state_pkg::*;
#(
  parameter int PORT_WIDTH = 8
) (
  input wire logic                  clk_sys,
  input wire logic                  reset,
  input wire logic                  rstIn_n,
  input wire logic                  lockoutThresholdOk,
  input wire logic                  automaticPowerDown,
  input wire logic [3:0]            portMode,
  input wire logic [PORT_WIDTH-1:0] portOe,
  input wire logic [7:0]            memoryMappingRegister,
  input wire logic [7:0]            otherCtrl,
  input wire logic                  flashReadArray,
  input wire logic                  flashWriteEnable,
  input wire logic                  flashAbort,
  input wire logic                  addressBlocked,
  input wire logic                  testChannelEnable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  // synchroniser plus output flop: pin level shows three edges late
  sequence sInReset;
    (!rstIn_n)[*4];
  endsequence
  // power-down has one more stage through the phase register
  sequence sInApd;
    (automaticPowerDown && rstIn_n)[*6];
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_READ_ARRAY: assert property (sInReset |-> flashReadArray && !flashWriteEnable)
    else $error("flash not in read mode during reset");
  AST_ABORT_PULSE: assert property (flashAbort |=> !flashAbort)
    else $error("abort pulse longer than one cycle");
  AST_WRITE_LOCK: assert property ((!lockoutThresholdOk)[*4] |-> !flashWriteEnable)
    else $error("flash write below lockout threshold");
  AST_PINS_RESET: assert property ((!rstIn_n && portMode != MODE_LOGIC_IO)[*4] |-> portOe == '0)
    else $error("pin driven during reset");
  // mode must have stood one cycle, the pin enable is registered after it
  AST_PERIPH_APD: assert property (sInApd ##0 (portMode == MODE_PERIPH_IO &&
    $past(portMode) == MODE_PERIPH_IO) |-> portOe == '0) else $error("peripheral pin driven in power-down");
  AST_ADDR_BLOCK: assert property (sInApd |-> addressBlocked)
    else $error("address not blocked in power-down");
  AST_TEST_CHAN: assert property (!$past(reset) |-> testChannelEnable)
    else $error("test channel disabled");
  AST_MAP_BITS: assert property (sInReset |-> !memoryMappingRegister[MAP_PERIPHERAL_IO_ENABLE_BIT] &&
    !memoryMappingRegister[MAP_SRAM_PROG_BIT]) else $error("mapping bits not cleared in reset");
  AST_OTHER_CLR: assert property (sInReset |-> otherCtrl == CTRL_RESET_VALUE)
    else $error("control register not cleared in reset");
endmodule

bind psd_reset_state_control psd_reset_state_control_sva #(.PORT_WIDTH(PORT_WIDTH)) u_sva (
  .clk_sys               (clk_sys),
  .reset                 (reset),
  .rstIn_n               (rstIn_n),
  .lockoutThresholdOk    (lockoutThresholdOk),
  .automaticPowerDown    (automaticPowerDown),
  .portMode              (portMode),
  .portOe                (portOe),
  .memoryMappingRegister (memoryMappingRegister),
  .otherCtrl             (otherCtrl),
  .flashReadArray        (flashReadArray),
  .flashWriteEnable      (flashWriteEnable),
  .flashAbort            (flashAbort),
  .addressBlocked        (addressBlocked),
  .testChannelEnable     (testChannelEnable)
);

//--- verif/mcu_reset_model.sv
// behavioural model of the supervisory reset source
`timescale 1ns/1ps
module mcu_reset_model (
  input  wire logic clk_sys,
  output logic      rstIn_n,
  output logic      powerOnDetect
);
  // power just applied: reset held low, power-on flag up
  initial begin
    rstIn_n = 1'h0;
    powerOnDetect = 1'h1;
  end
  // assert reset low; warm unless power was just applied
  task automatic assert_reset(input logic fromPower);
    @(posedge clk_sys);
    rstIn_n <= 1'h0;
    powerOnDetect <= fromPower;
  endtask
  // release to normal operation
  task automatic release_reset();
    @(posedge clk_sys);
    rstIn_n <= 1'h1;
    powerOnDetect <= 1'h0;
  endtask
endmodule

//--- verif/psd_reset_state_control_tb_top.sv
// self-checking bench for the reset and power-state controller
`timescale 1ns/1ps
module psd_reset_state_control_tb_top;
  import reset_state_pkg::*;
  localparam logic [7:0] MAP_CFG = 8'hA5;
  logic       clk_sys = 1'h0;
  logic       reset = 1'h1;
  logic       rstIn_n, powerOnDetect, lockoutThresholdOk, automaticPowerDown, batterySwitched;
  logic       standbyIndicatorEnable, ctrlWrite, flashWriteReq, flashBusyIn;
  logic [1:0] ctrlSelect;
  logic [3:0] portMode;
  logic [7:0] mcuOut, mcuOe, logicOut, logicOe, addrLatched, periphOut, periphOe, ctrlWdata;
  logic [7:0] macrocellNext, macrocellAsyncClr, macrocellAsyncSet, portOut, portOe, macrocellQ;
  logic [7:0] powerMgmtCtrlA, powerMgmtCtrlC, memoryMappingRegister, otherCtrl;
  logic       configLoaded, flashReadArray, flashWriteEnable, flashAbort, powerUpReset, lowPowerMode;
  logic       addressBlocked, testChannelEnable, standbyIndicatorPin, standbyIndicatorOe;
  logic [7:0] abortCnt = 8'h00;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         cyc = 0;

  always #2.5 clk_sys = ~clk_sys;

  psd_reset_state_control #(.MAP_CONFIG(MAP_CFG)) dut (
    .clk_sys(clk_sys), .reset(reset), .rstIn_n(rstIn_n), .powerOnDetect(powerOnDetect),
    .lockoutThresholdOk(lockoutThresholdOk), .automaticPowerDown(automaticPowerDown),
    .batterySwitched(batterySwitched), .standbyIndicatorEnable(standbyIndicatorEnable), .portMode(portMode),
    .mcuOut(mcuOut), .mcuOe(mcuOe), .logicOut(logicOut), .logicOe(logicOe), .addrLatched(addrLatched),
    .periphOut(periphOut), .periphOe(periphOe), .macrocellNext(macrocellNext),
    .macrocellAsyncClr(macrocellAsyncClr), .macrocellAsyncSet(macrocellAsyncSet), .ctrlWrite(ctrlWrite),
    .ctrlSelect(ctrlSelect), .ctrlWdata(ctrlWdata), .flashWriteReq(flashWriteReq), .flashBusyIn(flashBusyIn),
    .portOut(portOut), .portOe(portOe), .macrocellQ(macrocellQ), .powerMgmtCtrlA(powerMgmtCtrlA),
    .powerMgmtCtrlC(powerMgmtCtrlC), .memoryMappingRegister(memoryMappingRegister), .otherCtrl(otherCtrl),
    .configLoaded(configLoaded), .flashReadArray(flashReadArray), .flashWriteEnable(flashWriteEnable),
    .flashAbort(flashAbort), .powerUpReset(powerUpReset), .lowPowerMode(lowPowerMode),
    .addressBlocked(addressBlocked), .testChannelEnable(testChannelEnable),
    .standbyIndicatorPin(standbyIndicatorPin), .standbyIndicatorOe(standbyIndicatorOe)
  );
  mcu_reset_model mcu (.clk_sys(clk_sys), .rstIn_n(rstIn_n), .powerOnDetect(powerOnDetect));

  ////////////////////////////////////////////////////////////////////////////////
  // count abort pulses; a level would count more than once
  always @(posedge clk_sys) begin
    if (flashAbort) abortCnt <= abortCnt + 8'h01;
  end
  // hang guard, far above the roughly 140 cycles needed
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // wait edges, then sample at the falling edge where outputs are settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // one control write, honoured at the edge that samples the strobe
  task automatic write_ctrl(input logic [1:0] sel, input logic [7:0] data);
    @(posedge clk_sys);
    ctrlWrite <= 1'h1;
    ctrlSelect <= sel;
    ctrlWdata <= data;
    @(posedge clk_sys);
    ctrlWrite <= 1'h0;
    @(negedge clk_sys);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // power-up reset, writes, warm reset with pin modes, then power-down
  initial begin
    {lockoutThresholdOk, automaticPowerDown, batterySwitched, standbyIndicatorEnable} = '0;
    {ctrlWrite, flashWriteReq, flashBusyIn, ctrlSelect, ctrlWdata, mcuOut, logicOut} = '0;
    {addrLatched, periphOut, macrocellNext, macrocellAsyncClr, macrocellAsyncSet} = '0;
    mcuOe = 8'hFF;
    logicOe = 8'hF0;
    periphOe = 8'hFF;
    portMode = MODE_MCU_IO;
    repeat (10) @(posedge clk_sys);
    reset <= 1'h0;
    settle(16);
    chk("puFlag", 1'h1, powerUpReset);
    chk("cfgDone", 1'h1, configLoaded);
    chk("testChan", 1'h1, testChannelEnable);
    chk("mapPu", MAP_CFG & 8'h7E, memoryMappingRegister);
    chk("macroPu", 8'h00, macrocellQ);
    chk("lowPwr", 1'h0, lowPowerMode);
    mcu.release_reset();
    @(posedge clk_sys);
    flashWriteReq <= 1'h1;
    settle(20);
    chk("puDone", 1'h0, powerUpReset);
    chk("wrLocked", 1'h0, flashWriteEnable);
    @(posedge clk_sys);
    lockoutThresholdOk <= 1'h1;
    settle(6);
    chk("wrOpen", 1'h1, flashWriteEnable);
    write_ctrl(2'h0, 8'h08);
    write_ctrl(2'h1, 8'h3C);
    write_ctrl(2'h2, 8'hFF);
    write_ctrl(2'h3, 8'h5A);
    chk("lowPwrSet", 1'h1, lowPowerMode);
    chk("map", 8'hFF, memoryMappingRegister);
    // warm reset while a flash program runs
    @(posedge clk_sys);
    flashBusyIn <= 1'h1;
    macrocellAsyncSet <= 8'h0F;
    macrocellAsyncClr <= 8'h03;
    mcu.assert_reset(1'h0);
    settle(6);
    chk("abort", 8'h01, abortCnt);
    chk("rdArray", 1'h1, flashReadArray);
    chk("warm", 1'h0, powerUpReset);
    chk("ctrlA", 8'h08, powerMgmtCtrlA);
    chk("ctrlC", 8'h3C, powerMgmtCtrlC);
    chk("mapWarm", MAP_CFG & 8'h7E, memoryMappingRegister);
    chk("other", 8'h00, otherCtrl);
    chk("macroWarm", 8'h0C, macrocellQ);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      portMode <= 4'h1 << i;
      settle(2);
      chk("oeReset", (i == 1) ? 8'hF0 : 8'h00, portOe);
    end
    mcu.release_reset();
    @(posedge clk_sys);
    flashBusyIn <= 1'h0;
    macrocellAsyncSet <= 8'h00;
    macrocellAsyncClr <= 8'h00;
    portMode <= MODE_MCU_IO;
    mcuOut <= 8'hC3;
    macrocellNext <= 8'h96;
    settle(20);
    chk("mcuRun", 8'hC3, portOut);
    chk("macroRun", 8'h96, macrocellQ);
    write_ctrl(2'h3, 8'h5A);
    // power-down: MCU pins and registers hold, peripheral pins float, writes refused
    @(posedge clk_sys);
    automaticPowerDown <= 1'h1;
    settle(8);
    chk("addrBlk", 1'h1, addressBlocked);
    chk("testApd", 1'h1, testChannelEnable);
    @(posedge clk_sys);
    mcuOut <= 8'h00;
    macrocellNext <= 8'h00;
    settle(4);
    chk("mcuHold", 8'hC3, portOut);
    chk("macroApd", 8'h96, macrocellQ);
    chk("mapApd", MAP_CFG & 8'h7E, memoryMappingRegister);
    write_ctrl(2'h3, 8'h11);
    chk("otherApd", 8'h5A, otherCtrl);
    chk("ctrlAApd", 8'h08, powerMgmtCtrlA);
    @(posedge clk_sys);
    portMode <= MODE_PERIPH_IO;
    standbyIndicatorEnable <= 1'h1;
    batterySwitched <= 1'h1;
    settle(8);
    chk("periphApd", 8'h00, portOe);
    chk("sbyPin", 1'h1, standbyIndicatorPin);
    chk("sbyOe", 1'h1, standbyIndicatorOe);
    // power cycled: flag set again, power-management pair and macrocells cleared
    mcu.assert_reset(1'h1);
    settle(6);
    chk("puAgain", 1'h1, powerUpReset);
    chk("ctrlAPu", 8'h00, powerMgmtCtrlA);
    chk("ctrlCPu", 8'h00, powerMgmtCtrlC);
    chk("macroPu2", 8'h00, macrocellQ);
    complete_run();
  end
endmodule
